// ===== design/rsb_pkg.sv
// package: constants, register map and layouts of the ring sample buffer
// Behaviour
// (R1) In ring mode a full buffer wraps to address 0 and overwrites oldest samples.
// (R2) Host-programmable write pointer and separate host-programmable read pointer.
// (R3) Ring mode: data-available sets on each store, clears on write pointer load.
// (R4) Half-full sets when write pointer exceeds half size, by load or by storing.
// (R5) Half-full clears when host loads write pointer below half size.
// (R6) Ring full and next write equals preset start: next sample sets overflow.
// (R7) In ring mode overflow does not halt storing; older entries are overwritten.
// (R8) Buffer reset clears all buffer flags and zeroes both pointers; the code leaves the over-range flag unchanged.
// (R9) A command loads the write pointer from a host address.
// (R10) A command loads the read pointer from a host address.
// (R11) Host can read back current write and read pointer values.
// (R12) Write pointer is captured when stop condition is met; host can read it.
// (R13) Reading does not remove data; reload read pointer to re-read.
// (R14) Host selects offset binary or two's complement output encoding.
// (R15) Two's complement is offset code minus mid-scale, sign-extended to 16 bits.
// (R16) 12-bit: 0800h gives 0000h, 0000h gives F800h; 16-bit: 8000h gives 0000h.
// (R17) Offset code is (volts times gain plus offset) times 2^n over span.
// (R18) Over-range sets on min or max code stored; clears on error reset command.
// (R19) Over-range does not stop acquisition.
// (R20) Buffer holds 256K words; pointers span that depth.
// (R21) Host selects FIFO mode or ring mode; device follows it.
// (R22) Read pointer advances and wraps after each data read; write pointer likewise.
package rsb_pkg;
  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int ADDR_W = 18;
  localparam int DEPTH = 262144;
  localparam logic [17:0] HALF_SIZE = 18'h20000;
  localparam logic [17:0] PTR_LAST = 18'h3FFFF;
  localparam logic [17:0] PTR_RESET = 18'h00000;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WPTR = 8'h0C;
  localparam logic [7:0] OFS_RPTR = 8'h10;
  localparam logic [7:0] OFS_TRIG_WPTR = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;

  // ctrl fields
  localparam int CTRL_RING = 0;
  localparam int CTRL_TWOS = 1;
  localparam int CTRL_RES16 = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // cmd fields (write one to act)
  localparam int CMD_BUF_RESET = 0;
  localparam int CMD_ERR_RESET = 1;
  // status fields
  localparam int ST_READY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_OVF = 2;
  localparam int ST_RANGE = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rsb_pkg

// ===== design/rsb_ring_sample_buffer.sv
// module: ring sample buffer with axi4-lite register slave
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module rsb_ring_sample_buffer (
  input wire logic aclk,
  input wire logic aresetn,
  // converter side
  input wire logic sample_valid,
  input wire logic [15:0] sample_code,
  input wire logic stop_met,
  output logic fifo_halt,
  // axi4-lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************************
  // overview
  // ***************************************************************
  // at most one sample a cycle, stored at the write pointer
  // host moves both pointers and reads the data port
  // ring mode overwrites the oldest words without end
  // fifo mode keeps a fill level, stops once overflowed
  // memory has no reset: unwritten words read as garbage
  // encoding fixed at store time, not at read time

  // ***************************************************************
  // state
  // ***************************************************************
  logic [15:0] mem [0:rsb_pkg::DEPTH-1];
  logic [17:0] wptr_reg, rptr_reg, start_reg, trig_reg;
  logic [2:0] ctrl_reg;
  logic ready_reg, half_reg, ovf_reg, range_reg, wrapped_reg;
  logic [17:0] count_reg; // fifo fill level
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic aw_have_reg, w_have_reg;

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [17:0] rsb_inc(input logic [17:0] p);
    rsb_inc = (p == rsb_pkg::PTR_LAST) ? rsb_pkg::PTR_RESET : p + 18'h00001; // see (R22)
  endfunction : rsb_inc

  // two's complement: subtract mid-scale, sign-extend to 16 bits
  function automatic logic [15:0] rsb_enc(input logic [15:0] c, input logic [2:0] ctl);
    logic [15:0] r;
    r = c;
    if (ctl[rsb_pkg::CTRL_TWOS]) begin // see (R14)
      if (ctl[rsb_pkg::CTRL_RES16])
        r = {~c[15], c[14:0]}; // see (R15) see (R16)
      else
        r = {{5{~c[11]}}, c[10:0]}; // see (R15) see (R16)
    end
    rsb_enc = r;
  endfunction : rsb_enc

  // ***************************************************************
  // bus decode
  // ***************************************************************
  logic wr_go, rd_go, ring;
  logic [7:0] wa;
  logic [31:0] wd;
  assign ring = ctrl_reg[rsb_pkg::CTRL_RING]; // see (R21)
  assign wa = aw_have_reg ? awaddr_reg : s_axi_awaddr;
  assign wd = w_have_reg ? wdata_reg : s_axi_wdata;
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_go = (aw_have_reg || s_axi_awvalid) && (w_have_reg || s_axi_wvalid)
                 && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  logic ld_w, ld_r, buf_rst, err_rst, rd_data, wr_ok, fifo_empty, store;
  assign ld_w = wr_go && wa == rsb_pkg::OFS_WPTR; // see (R9)
  assign ld_r = wr_go && wa == rsb_pkg::OFS_RPTR; // see (R10)
  assign buf_rst = wr_go && wa == rsb_pkg::OFS_CMD && wd[rsb_pkg::CMD_BUF_RESET];
  assign err_rst = wr_go && wa == rsb_pkg::OFS_CMD && wd[rsb_pkg::CMD_ERR_RESET];
  assign rd_data = rd_go && s_axi_araddr == rsb_pkg::OFS_DATA;
  assign wr_ok = wa == rsb_pkg::OFS_CTRL || wa == rsb_pkg::OFS_CMD
                 || wa == rsb_pkg::OFS_WPTR || wa == rsb_pkg::OFS_RPTR;
  assign fifo_empty = count_reg == 18'h00000 && !wrapped_reg;
  // fifo mode drops samples once overflowed; ring keeps going
  assign store = sample_valid && !buf_rst && (ring || !ovf_reg) // see (R7) see (R19)
                 && !(!ring && wrapped_reg);
  assign fifo_halt = !ring && ovf_reg;

  // write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
    end else if (wr_go) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsb_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? rsb_pkg::RESP_OKAY : rsb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register; byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ctrl_reg <= rsb_pkg::CTRL_RESET;
    else if (wr_go && wa == rsb_pkg::OFS_CTRL && s_axi_wstrb[0])
      ctrl_reg <= wd[2:0]; // see (R14) see (R21)
  end

  // ***************************************************************
  // sample storage
  // ***************************************************************
  // memory has no reset: contents are undefined until written
  always_ff @(posedge aclk) begin
    if (store)
      mem[wptr_reg] <= rsb_enc(sample_code, ctrl_reg); // see (R1) see (R20)
  end

  // write pointer and preset start address; reset command first
  logic [17:0] wptr_next, start_next;
  always_comb begin
    wptr_next = wptr_reg;
    start_next = start_reg;
    if (buf_rst) begin
      wptr_next = rsb_pkg::PTR_RESET; // see (R8)
      start_next = rsb_pkg::PTR_RESET;
    end else if (ld_w) begin
      wptr_next = wd[17:0]; // see (R2) see (R9)
      start_next = wd[17:0];
    end else if (store) begin
      wptr_next = rsb_inc(wptr_reg); // see (R1) see (R22)
    end
  end

  // write pointer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg <= rsb_pkg::PTR_RESET;
      start_reg <= rsb_pkg::PTR_RESET;
    end else begin
      wptr_reg <= wptr_next;
      start_reg <= start_next;
    end
  end

  // trigger capture of the write position at stop
  always_ff @(posedge aclk) begin
    if (!aresetn)
      trig_reg <= rsb_pkg::PTR_RESET;
    else if (stop_met)
      trig_reg <= wptr_reg; // see (R12)
  end

  // read pointer; reads never erase data
  logic [17:0] rptr_next;
  always_comb begin
    rptr_next = rptr_reg;
    if (buf_rst)
      rptr_next = rsb_pkg::PTR_RESET; // see (R8)
    else if (ld_r)
      rptr_next = wd[17:0]; // see (R2) see (R10) see (R13)
    else if (rd_data)
      rptr_next = rsb_inc(rptr_reg); // see (R22)
  end

  // read pointer register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rptr_reg <= rsb_pkg::PTR_RESET;
    else
      rptr_reg <= rptr_next;
  end

  // fill level with its carry as the wrap marker
  logic [18:0] level_next;
  logic fifo_pop;
  assign fifo_pop = rd_data && !ring && !fifo_empty;
  always_comb begin
    level_next = {wrapped_reg, count_reg};
    if (buf_rst || ld_w) begin
      level_next = 19'h00000;
    end else begin
      if (store && !fifo_pop)
        level_next = level_next + 19'h00001;
      else if (!store && fifo_pop)
        level_next = level_next - 19'h00001;
      // once round, the ring stays round until reload
      if (ring && wrapped_reg)
        level_next[18] = 1'b1;
    end
  end

  // level registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 18'h00000;
      wrapped_reg <= 1'b0;
    end else begin
      count_reg <= level_next[17:0];
      wrapped_reg <= level_next[18];
    end
  end

  // ***************************************************************
  // status flags; buffer reset beats a set in its cycle, a set beats error reset
  // ***************************************************************

  // data ready: ring sets on store, fifo follows the level
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ready_reg <= 1'b0;
    else if (buf_rst)
      ready_reg <= 1'b0; // see (R8)
    else if (!ring)
      ready_reg <= !fifo_empty; // one cycle behind the level
    else if (store)
      ready_reg <= 1'b1; // see (R3)
    else if (ld_w)
      ready_reg <= 1'b0; // see (R3)
  end

  // half full: ring looks at the pointer, fifo at the level
  always_ff @(posedge aclk) begin
    if (!aresetn)
      half_reg <= 1'b0;
    else if (buf_rst)
      half_reg <= 1'b0; // see (R8)
    else if (!ring)
      half_reg <= count_reg > rsb_pkg::HALF_SIZE;
    else if (ld_w)
      half_reg <= wd[17:0] > rsb_pkg::HALF_SIZE; // see (R4) see (R5)
    else if (store && rsb_inc(wptr_reg) > rsb_pkg::HALF_SIZE)
      half_reg <= 1'b1; // see (R4)
  end

  // overflow: sticky until buffer reset, so no wrap goes unseen
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ovf_reg <= 1'b0;
    else if (buf_rst)
      ovf_reg <= 1'b0; // see (R8)
    else if (ring && store && wrapped_reg && wptr_reg == start_reg)
      ovf_reg <= 1'b1; // see (R6) see (R7)
    else if (!ring && sample_valid && wrapped_reg)
      ovf_reg <= 1'b1;
  end

  // over-range on min or max code
  always_ff @(posedge aclk) begin
    if (!aresetn)
      range_reg <= 1'b0;
    else if (store && (sample_code == 16'h0000 || (ctrl_reg[rsb_pkg::CTRL_RES16] ?
             sample_code == 16'hFFFF : sample_code == 16'h0FFF)))
      range_reg <= 1'b1; // see (R18) see (R19)
    else if (err_rst)
      range_reg <= 1'b0; // see (R18)
  end

  // ***************************************************************
  // read channel
  // ***************************************************************

  // read data and response chosen ahead of the answer stage
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  always_comb begin
    rdata_next = 32'h00000000;
    rresp_next = rsb_pkg::RESP_OKAY;
    case (s_axi_araddr)
      rsb_pkg::OFS_CTRL: begin
        rdata_next = {29'h00000000, ctrl_reg};
      end
      rsb_pkg::OFS_CMD: begin
        rdata_next = 32'h00000000; // commands read back as zero
      end
      rsb_pkg::OFS_STATUS: begin
        rdata_next = {28'h0000000, range_reg, ovf_reg, half_reg, ready_reg};
      end
      rsb_pkg::OFS_WPTR: begin
        rdata_next = {14'h0000, wptr_reg}; // see (R11)
      end
      rsb_pkg::OFS_RPTR: begin
        rdata_next = {14'h0000, rptr_reg}; // see (R11)
      end
      rsb_pkg::OFS_TRIG_WPTR: begin
        rdata_next = {14'h0000, trig_reg}; // see (R12)
      end
      rsb_pkg::OFS_DATA: begin
        rdata_next = {16'h0000, mem[rptr_reg]}; // see (R13)
      end
      default: begin
        rresp_next = rsb_pkg::RESP_SLVERR; // hole in the map
      end
    endcase
  end

  // answer registers; held until the master takes them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= rsb_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rsb_ring_sample_buffer

// ===== tb/rsb_chk.sv
// checker: bus handshake and response assertions for the ring sample buffer
`timescale 1ns/1ps
module rsb_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ************************************************
  // properties
  // ************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // write takes both channels in one beat when idle
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer_next: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write answer late");
  chk_rd_answer_next: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  chk_aw_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  // hole in the map must answer with an error and zero data
  chk_unmapped_read: assert property (
    s_rd_take ##0 (s_axi_araddr > 8'h18)
    |=> s_axi_rresp == rsb_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_status_ro: assert property (
    s_wr_take ##0 (s_axi_awaddr == rsb_pkg::OFS_STATUS)
    |=> s_axi_bresp == rsb_pkg::RESP_SLVERR)
    else $error("status write accepted");
endmodule : rsb_chk
bind rsb_ring_sample_buffer rsb_chk rsb_chk_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ===== tb/rsb_conv_model.sv
// model: converter side that feeds samples and stop events
`timescale 1ns/1ps
module rsb_conv_model (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [15:0] code,
  input wire logic stop,
  output logic sample_valid,
  output logic [15:0] sample_code,
  output logic stop_met
);
  // ************************************************
  // one-cycle pulses
  // ************************************************
  initial begin
    sample_valid = 1'b0;
    sample_code = 16'h5A5A;
    stop_met = 1'b0;
  end
  // code line toggles when idle so stale data never looks settled
  always @(posedge aclk) begin
    sample_valid <= fire;
    sample_code <= fire ? code : ~sample_code;
    stop_met <= stop;
  end
endmodule : rsb_conv_model

// ===== tb/tb_top.sv
// testbench: ring sample buffer over axi4-lite with a converter model
`timescale 1ns/1ps
module tb_top;
  // ************************************************
  // signals, clock and instances
  // ************************************************
  logic aclk;
  logic aresetn = 1'b0, fire = 1'b0, stop = 1'b0, sample_valid, stop_met, fifo_halt;
  logic [15:0] code = 16'h0000, sample_code;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  int err_total = 0, cmp_count = 0;
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  rsb_ring_sample_buffer rsb_ring_sample_buffer_inst (
    .aclk, .aresetn, .sample_valid, .sample_code, .stop_met, .fifo_halt, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  rsb_conv_model rsb_conv_model_inst (
    .aclk, .fire, .code, .stop, .sample_valid, .sample_code, .stop_met
  );
  // compare task, counts every check
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bus write; each channel dropped at its own taking edge, one idle edge after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  // bus read; rready held from the start, data taken at the answer edge
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic rck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_q & m, e);
  endtask : rck
  task automatic smp(input logic [15:0] c);
    fire <= 1'b1;
    code <= c;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : smp
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_wrap();
    wr(rsb_pkg::OFS_CTRL, 32'h1);
    wr(rsb_pkg::OFS_WPTR, 32'h3FFFE);
    rck(rsb_pkg::OFS_WPTR, 32'h3FFFF, 32'h3FFFE);
    rck(rsb_pkg::OFS_STATUS, 32'h1, 32'h0);
    smp(16'h0123);
    smp(16'h0456);
    rck(rsb_pkg::OFS_WPTR, 32'h3FFFF, 32'h0);
    rck(rsb_pkg::OFS_STATUS, 32'h1, 32'h1);
    wr(rsb_pkg::OFS_RPTR, 32'h3FFFF);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h0456);
    rck(rsb_pkg::OFS_RPTR, 32'h3FFFF, 32'h0);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_enc();
    wr(rsb_pkg::OFS_CTRL, 32'h3);
    wr(rsb_pkg::OFS_WPTR, 32'h100);
    smp(16'h0000);
    smp(16'h0FFF);
    wr(rsb_pkg::OFS_CTRL, 32'h7);
    smp(16'h8000);
    smp(16'h0000);
    wr(rsb_pkg::OFS_CTRL, 32'h5);
    smp(16'h1234);
    wr(rsb_pkg::OFS_RPTR, 32'h100);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'hF800);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h07FF);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h0000);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h8000);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h1234);
    wr(rsb_pkg::OFS_RPTR, 32'h100);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'hF800);
    rck(rsb_pkg::OFS_STATUS, 32'h8, 32'h8);
    wr(rsb_pkg::OFS_CMD, 32'h2);
    rck(rsb_pkg::OFS_STATUS, 32'h8, 32'h0);
    $display("test encoding done");
  endtask : t_enc
  task automatic t_half();
    wr(rsb_pkg::OFS_WPTR, 32'h20000);
    rck(rsb_pkg::OFS_STATUS, 32'h2, 32'h0);
    smp(16'h0200);
    rck(rsb_pkg::OFS_STATUS, 32'h3, 32'h3);
    wr(rsb_pkg::OFS_WPTR, 32'h10);
    rck(rsb_pkg::OFS_STATUS, 32'h3, 32'h0);
    wr(rsb_pkg::OFS_WPTR, 32'h20001);
    rck(rsb_pkg::OFS_STATUS, 32'h2, 32'h2);
    $display("test half done");
  endtask : t_half
  // capture must hold after the pointer moves on
  task automatic t_trig();
    stop <= 1'b1;
    @(posedge aclk);
    stop <= 1'b0;
    repeat (2) @(posedge aclk);
    smp(16'h0300);
    rck(rsb_pkg::OFS_TRIG_WPTR, 32'h3FFFF, 32'h20001);
    $display("test trigger done");
  endtask : t_trig
  task automatic t_rst();
    wr(rsb_pkg::OFS_CMD, 32'h1);
    rck(rsb_pkg::OFS_STATUS, 32'hF, 32'h0);
    rck(rsb_pkg::OFS_WPTR, 32'h3FFFF, 32'h0);
    rck(rsb_pkg::OFS_RPTR, 32'h3FFFF, 32'h0);
    rck(8'h40, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, resp_q}, {30'h0, rsb_pkg::RESP_SLVERR});
    wr(rsb_pkg::OFS_STATUS, 32'hF);
    chk({30'h0, resp_q}, {30'h0, rsb_pkg::RESP_SLVERR});
    $display("test reset done");
  endtask : t_rst
  // fifo mode: level drives ready, reads drain it, no halt
  task automatic t_fifo();
    wr(rsb_pkg::OFS_CTRL, 32'h0);
    wr(rsb_pkg::OFS_CMD, 32'h1);
    smp(16'h0111);
    smp(16'h0222);
    rck(rsb_pkg::OFS_STATUS, 32'h5, 32'h1);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h0111);
    rck(rsb_pkg::OFS_DATA, 32'hFFFF, 32'h0222);
    rck(rsb_pkg::OFS_STATUS, 32'h1, 32'h0);
    chk({31'h0, fifo_halt}, 32'h0);
    $display("test fifo done");
  endtask : t_fifo
  task automatic close_out();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_wrap();
    t_enc();
    t_half();
    t_trig();
    t_rst();
    t_fifo();
    close_out();
  end
  // watchdog: tests need about two hundred cycles, allow twenty thousand
  initial begin
    #160000;
    err_total++;
    close_out();
  end
endmodule : tb_top
